// ==== tb_timer_chan0_polarity_select.sv ====
// Self-checking testbench for the channel 0 polarity select block
`timescale 1ns/1ps
module tb_timer_chan0_polarity_select;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lvl = 1'b0;
  logic [1:0] sel = 2'h0;
  logic s0, s1, s2, cref, cout, coe, cap, filt, rsv;
  logic [31:0] rdata;
  int errors = 0;
  int n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  tcp_far_side i_tcp_far_side (.clk_sys(clk_sys), .sel(sel), .lvl(lvl), .src0(s0),
    .src1(s1), .src2(s2), .cmp_ref(cref));
  tcp_chan0_polarity i_tcp_chan0_polarity (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chan0_filtered_input(s0),
    .chan1_filtered_to_chan0(s1), .trig_input(s2), .compare_ref(cref), .compare_out(cout),
    .compare_oe(coe), .capture_event(cap), .filtered_chan_input(filt), .reserved_cfg(rsv));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk_sys) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_sys) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs;
    rd_reg(tcp_pkg::ADDR_CHCTL, 32'h0000_0000);
    rd_reg(tcp_pkg::ADDR_MODE, 32'h0000_0000);
    rd_reg(8'h40, 32'h0000_0000);
    wr_reg(tcp_pkg::ADDR_CHCTL, 32'hffff_ffff);
    rd_reg(tcp_pkg::ADDR_CHCTL, 32'h0000_00bb);
    wr_reg(tcp_pkg::ADDR_MODE, 32'h0000_0003);
    rd_reg(tcp_pkg::ADDR_MODE, 32'h0000_0000);
    wr_reg(tcp_pkg::ADDR_CHCTL, 32'h0000_0000);
  endtask
  task automatic t_out;
    @(posedge clk_sys) lvl <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      // Complementary bit left zero in output mode
      wr_reg(tcp_pkg::ADDR_CHCTL, {30'h0, p[0], 1'b1});
      settle;
      chk(cout, {31'h0, ~p[0]});
      chk(coe, 32'h1);
    end
    wr_reg(tcp_pkg::ADDR_CHCTL, 32'h0000_0000);
    settle;
    chk(coe, 32'h0);
  endtask
  task automatic t_in(input logic [1:0] m, input logic np, input logic pol);
    logic inv, rise, fall, bad;
    logic [1:0] code;
    inv = pol & ~np;
    bad = np & ~pol;
    rise = ~bad & ~(pol & ~np);
    fall = pol;
    code = bad ? 2'h0 : (np ? 2'h3 : (pol ? 2'h2 : 2'h1));
    wr_reg(tcp_pkg::ADDR_CHCTL, 32'h0000_0000);
    wr_reg(tcp_pkg::ADDR_MODE, {30'h0, m});
    @(posedge clk_sys) begin sel <= m; lvl <= 1'b0; end
    wr_reg(tcp_pkg::ADDR_CHCTL, {28'h0, np, 1'b0, pol, 1'b1});
    settle;
    chk(filt, {31'h0, inv});
    chk(rsv, {31'h0, bad});
    rd_reg(tcp_pkg::ADDR_STATUS, {28'h0, bad, code, inv});
    @(posedge clk_sys) lvl <= 1'b1;
    @(posedge clk_sys);
    #1 chk(cap, {31'h0, rise});
    @(posedge clk_sys);
    #1 chk(cap, 32'h0);
    chk(filt, {31'h0, ~inv});
    @(posedge clk_sys) lvl <= 1'b0;
    @(posedge clk_sys);
    #1 chk(cap, {31'h0, fall});
    wr_reg(tcp_pkg::ADDR_CHCTL, {28'h0, np, 1'b0, pol, 1'b0});
    @(posedge clk_sys) lvl <= 1'b1;
    @(posedge clk_sys);
    #1 chk(cap, 32'h0);
  endtask
  task automatic finish_test;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_out;
    for (int m = 1; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        t_in(m[1:0], c[1], c[0]);
      end
    end
    finish_test;
  end
endmodule

// ==== tcp_chan0_polarity.sv ====
// Channel 0 polarity selection, register port and edge qualification
// Behaviour
// - Output mode: polarity 0 gives active-high, 1 gives active-low output.
// - Input mode 00: rising edge active, input not inverted.
// - Input mode 01: falling edge active, input inverted.
// - Input mode 11: both edges active, not inverted; 10 is reserved.
// - Mode 00 selects output; other modes select input sources.
// - Enable gates compare output enable and capture events; compare_out itself is not gated; clear disables channel.
`timescale 1ns/1ps
module tcp_chan0_polarity (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic chan0_filtered_input,
  input wire logic chan1_filtered_to_chan0,
  input wire logic trig_input,
  input wire logic compare_ref,
  output logic compare_out,
  output logic compare_oe,
  output logic capture_event,
  output logic filtered_chan_input,
  output logic reserved_cfg
);
  logic [31:0] chctl;
  logic [31:0] next_chctl;
  logic [1:0] chan0_mode_select;
  logic [1:0] next_mode;
  logic [31:0] next_rdata;
  logic next_out;
  logic next_oe;
  logic next_cap;
  logic next_filt;
  logic next_rsv;
  logic src;
  logic rise;
  logic fall;
  tcp_pkg::tcp_cfg_s cfg;
  tcp_pkg::tcp_dec_s dec;

  assign cfg.enable = chctl[tcp_pkg::EN_BIT];
  assign cfg.polarity = chctl[tcp_pkg::POL_BIT];
  assign cfg.comp_polarity = chctl[tcp_pkg::NP_BIT];
  assign cfg.mode = chan0_mode_select;
  assign dec = tcp_pkg::tcp_decode(cfg);

  // Register writes
  always_comb begin
    next_chctl = chctl;
    next_mode = chan0_mode_select;
    if (wr && addr == tcp_pkg::ADDR_CHCTL) begin
      // Reserved bits are masked off on write
      next_chctl = wdata & tcp_pkg::CHCTL_WMASK;
    end
    // Mode is writable only while the channel is disabled
    if (wr && addr == tcp_pkg::ADDR_MODE && !chctl[tcp_pkg::EN_BIT]) begin
      next_mode = wdata[1:0];
    end
  end

  // Register reads, one cycle later; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        tcp_pkg::ADDR_CHCTL: next_rdata = chctl;
        tcp_pkg::ADDR_MODE: next_rdata = {30'h0000_0000, chan0_mode_select};
        tcp_pkg::ADDR_STATUS: next_rdata = {28'h000_0000, dec.reserved_combo,
                                            dec.edge_sel, dec.invert};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Input source by mode: 01 own input, 10 neighbour, 11 internal trigger
  always_comb begin
    unique case (chan0_mode_select)
      2'b01: src = chan0_filtered_input;
      2'b10: src = chan1_filtered_to_chan0;
      2'b11: src = trig_input;
      default: src = 1'b0;
    endcase
  end

  tcp_edge_detect u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .sig(src),
    .clear(dec.out_mode),
    .rise(rise),
    .fall(fall)
  );

  always_comb begin
    // Active-high when polarity is 0, active-low when 1
    next_out = dec.out_mode ? (compare_ref ^ cfg.polarity) : 1'b0;
    // Output pin only driven while enabled in output mode
    next_oe = dec.out_mode & cfg.enable;
    // Inversion of filtered input follows the polarity pair
    next_filt = dec.out_mode ? 1'b0 : (src ^ dec.invert);
    next_cap = 1'b0;
    if (cfg.enable && !dec.out_mode) begin
      unique case (dec.edge_sel)
        tcp_pkg::TCP_EDGE_RISE: next_cap = rise;
        tcp_pkg::TCP_EDGE_FALL: next_cap = fall;
        tcp_pkg::TCP_EDGE_BOTH: next_cap = rise | fall;
        default: next_cap = 1'b0;
      endcase
    end
    // Flags misuse of the complementary bit in either mode
    next_rsv = dec.reserved_combo | (dec.out_mode & cfg.comp_polarity);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chctl <= tcp_pkg::CHCTL_RESET;
      chan0_mode_select <= tcp_pkg::MODE_RESET;
      rdata <= 32'h0000_0000;
      compare_out <= 1'b0;
      compare_oe <= 1'b0;
      capture_event <= 1'b0;
      filtered_chan_input <= 1'b0;
      reserved_cfg <= 1'b0;
    end else begin
      chctl <= next_chctl;
      chan0_mode_select <= next_mode;
      rdata <= next_rdata;
      compare_out <= next_out;
      compare_oe <= next_oe;
      capture_event <= next_cap;
      filtered_chan_input <= next_filt;
      reserved_cfg <= next_rsv;
    end
  end

  a_rsvd_reads_zero: assert property (@(posedge clk_sys) disable iff (rst)
    rd && addr == tcp_pkg::ADDR_CHCTL |=> rdata[tcp_pkg::RSVD_BIT] == 1'b0)
    else $error("reserved bit read non-zero");

  a_out_level: assert property (@(posedge clk_sys) disable iff (rst)
    dec.out_mode |=> compare_out == ($past(compare_ref) ^ $past(cfg.polarity)))
    else $error("compare output level wrong");

  a_oe_enable: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg.enable |=> !compare_oe && !capture_event)
    else $error("disabled channel still active");

  a_rise_capture: assert property (@(posedge clk_sys) disable iff (rst)
    cfg.enable && !dec.out_mode && !cfg.polarity && !cfg.comp_polarity && rise
    |=> capture_event && filtered_chan_input)
    else $error("rising edge capture missed");

  a_fall_capture: assert property (@(posedge clk_sys) disable iff (rst)
    cfg.enable && !dec.out_mode && cfg.polarity && !cfg.comp_polarity && fall
    |=> capture_event && filtered_chan_input)
    else $error("falling edge capture missed");

  a_both_capture: assert property (@(posedge clk_sys) disable iff (rst)
    cfg.enable && !dec.out_mode && cfg.polarity && cfg.comp_polarity && (rise || fall)
    |=> capture_event)
    else $error("both edge capture missed");

  a_no_cap_output: assert property (@(posedge clk_sys) disable iff (rst)
    dec.out_mode |=> !capture_event)
    else $error("capture in output mode");

  a_np_in_output: assert property (@(posedge clk_sys) disable iff (rst)
    dec.out_mode && cfg.comp_polarity |=> reserved_cfg)
    else $error("complementary bit misuse not flagged");
endmodule

// ==== tcp_edge_detect.sv ====
// Edge detector on the selected filtered channel input
`timescale 1ns/1ps
module tcp_edge_detect (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sig,
  input wire logic clear,
  output logic rise,
  output logic fall
);
  logic last;
  logic next_last;

  always_comb begin
    next_last = clear ? 1'b0 : sig;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last <= 1'b0;
    end else begin
      last <= next_last;
    end
  end

  assign rise = sig & ~last & ~clear;
  assign fall = ~sig & last & ~clear;
endmodule

// ==== tcp_far_side.sv ====
// Far-side model: channel input sources and compare reference
`timescale 1ns/1ps
module tcp_far_side (
  input wire logic clk_sys,
  input wire logic [1:0] sel,
  input wire logic lvl,
  output logic src0,
  output logic src1,
  output logic src2,
  output logic cmp_ref
);
  logic tog = 1'b0;
  // Unselected sources toggle so a wrong source pick shows as stray edges
  always @(posedge clk_sys) begin
    tog <= ~tog;
  end
  assign src0 = (sel == 2'h1) ? lvl : tog;
  assign src1 = (sel == 2'h2) ? lvl : tog;
  assign src2 = (sel == 2'h3) ? lvl : tog;
  assign cmp_ref = lvl;
endmodule

// ==== tcp_pkg.sv ====
// Package for the channel 0 polarity select block
package tcp_pkg;
  localparam logic [7:0] ADDR_CHCTL = 8'h20;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam int EN_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int RSVD_BIT = 2;
  localparam int NP_BIT = 3;
  localparam int CH1_EN_BIT = 4;
  localparam int CH1_POL_BIT = 5;
  localparam int CH1_NP_BIT = 7;
  localparam logic [31:0] CHCTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CHCTL_WMASK = 32'h0000_00bb;
  localparam logic [1:0] MODE_OUTPUT = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    TCP_EDGE_NONE,
    TCP_EDGE_RISE,
    TCP_EDGE_FALL,
    TCP_EDGE_BOTH
  } tcp_edge_e;

  typedef struct packed {
    logic enable;
    logic polarity;
    logic comp_polarity;
    logic [1:0] mode;
  } tcp_cfg_s;

  typedef struct packed {
    logic out_mode;
    logic invert;
    logic reserved_combo;
    tcp_edge_e edge_sel;
  } tcp_dec_s;

  function automatic tcp_dec_s tcp_decode(input tcp_cfg_s c);
    tcp_dec_s d;
    d.out_mode = (c.mode == MODE_OUTPUT);
    d.invert = c.polarity & ~c.comp_polarity;
    d.reserved_combo = ~d.out_mode & c.comp_polarity & ~c.polarity;
    if (d.out_mode || d.reserved_combo) begin
      d.edge_sel = TCP_EDGE_NONE;
    end else begin
      unique case ({c.comp_polarity, c.polarity})
        2'b00: d.edge_sel = TCP_EDGE_RISE;
        2'b01: d.edge_sel = TCP_EDGE_FALL;
        default: d.edge_sel = TCP_EDGE_BOTH;
      endcase
    end
    return d;
  endfunction
endpackage
